// ### hdl/adb_pkg.sv
// constants shared by the conversion result double buffer
package adb_pkg;
  localparam int STATUS_W = 16;            // status word leading every serial frame
  localparam int DEF_NCH = 2;              // converter channels
  localparam int DEF_RES_W = 24;           // bits per conversion result
  localparam int CLK_PERIOD_NS = 8;        // 125 MHz system clock
  localparam int BRIEF_HIGH_NS = 16;       // level format: short high before a new fall
  localparam int PULSE_LOW_NS = 32;        // pulse format: low pulse width
  localparam int BRIEF_HIGH_CYC = (BRIEF_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_LOW_CYC = (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;                // width of the ready pin timers
  localparam logic FMT_LEVEL = 1'h0;       // ready_signal_format encodings
  localparam logic FMT_PULSE = 1'h1;
endpackage : adb_pkg

// ### hdl/adb_chan_stage.sv
// one channel: conversion-side output stage and host-side queue stage
module adb_chan_stage import adb_pkg::*; #(
  parameter int RES_W = DEF_RES_W
) (
  input wire logic clk,                 // system clock
  input wire logic rst_n,               // async reset, active low
  input wire logic flush,               // resync strobe, empties both stages
  input wire logic new_valid,           // one-cycle pulse: new conversion result
  input wire logic [RES_W-1:0] new_data, // the new result
  input wire logic read_done,           // one-cycle pulse: queue word fully shifted out
  output logic [RES_W-1:0] conv_q,      // conversion-side output stage
  output logic [RES_W-1:0] queue_q,     // host-side queue stage
  output logic unread,                  // queue holds a result not yet read
  output logic pending,                 // output stage is one result ahead of the queue
  output logic queue_load               // queue takes a new value this cycle
);
  // a zero-width result would leave nothing to stage
  if (RES_W < 1) begin : g_bad_width
    $error("result width must be at least one bit");
  end
  logic [RES_W-1:0] conv_ff;
  logic [RES_W-1:0] queue_ff;
  logic read_ff;
  logic behind_ff;

  // the output stage always follows the converter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_ff <= '0;
    end else if (flush) begin
      conv_ff <= '0;
    end else if (new_valid) begin
      conv_ff <= new_data;
    end
  end

  // queue stage and its read bookkeeping; an empty queue counts as read so the first result lands in both
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      queue_ff <= '0;
      read_ff <= 1'h1;
      behind_ff <= 1'h0;
    end else if (flush) begin
      queue_ff <= '0;
      read_ff <= 1'h1;
      behind_ff <= 1'h0;
    end else if (new_valid) begin
      if (read_ff || read_done || behind_ff) begin
        queue_ff <= new_data;           // both stages take the result
        read_ff <= 1'h0;
        behind_ff <= 1'h0;
      end else begin
        behind_ff <= 1'h1;              // stale result stays queued
      end
    end else if (read_done) begin
      if (behind_ff) begin
        queue_ff <= conv_ff;            // pending result moves up
        read_ff <= 1'h0;
        behind_ff <= 1'h0;
      end else begin
        read_ff <= 1'h1;                // contents stay, may be re-read
      end
    end
  end

  assign conv_q = conv_ff;
  assign queue_q = queue_ff;
  assign unread = !read_ff;
  assign pending = behind_ff;
  assign queue_load = !flush && ((new_valid && (read_ff || read_done || behind_ff)) || (!new_valid && read_done && behind_ff));

  a_conv_load: assert property (@(posedge clk) disable iff (!rst_n)
    new_valid && !flush |=> conv_ff == $past(new_data)) else $error("output stage missed a result");
  a_both_load: assert property (@(posedge clk) disable iff (!rst_n)
    new_valid && !flush && read_ff |=> queue_ff == conv_ff) else $error("stages differ after read result");
  a_keep_stale: assert property (@(posedge clk) disable iff (!rst_n)
    new_valid && !flush && !read_ff && !behind_ff && !read_done |=> $stable(queue_ff) && behind_ff)
    else $error("unread queue result was replaced");
  a_copy_pend: assert property (@(posedge clk) disable iff (!rst_n)
    read_done && !new_valid && behind_ff && !flush |=> queue_ff == $past(conv_ff) && !read_ff)
    else $error("pending result not moved to queue");
  a_drop_two: assert property (@(posedge clk) disable iff (!rst_n)
    new_valid && behind_ff && !flush |=> queue_ff == $past(new_data) && !behind_ff)
    else $error("third result not loaded in both stages");
  a_reread: assert property (@(posedge clk) disable iff (!rst_n)
    read_done && !new_valid && !behind_ff && !flush |=> $stable(queue_ff) && $stable(conv_ff))
    else $error("re-read changed a stage");
  a_flush_empty: assert property (@(posedge clk) disable iff (!rst_n)
    flush |=> queue_ff == '0 && conv_ff == '0 && read_ff) else $error("resync did not empty stages");
endmodule : adb_chan_stage

// ### hdl/adc_result_double_buffer.sv
// conversion result double buffer with serial readout and ready pin
// How it works
// - each channel keeps an output stage and a queue stage, one result each
// - serial words always come from the queue stage
// - a new result loads the output stage at once
// - if the queued result was read, the new result loads both stages
// - if the queued result is unread, it stays; only the output stage updates
// - reading a stale queued result moves the pending result into the queue
// - two results missed: the third loads both stages, older ones lost
// - re-reading an already-read queue changes nothing
// - level format: ready falls on new data, rises when all words shifted out
// - pulse format: each new queued result gives a short low pulse
// - level format, unread: ready stays low, brief high before next fall
// - pulse format, unread: one pulse skipped, half rate with no reads
// - status ready flags clear when the channel word is read, unless a pending result moves into the queue
// - resync strobe restarts conversions and empties every stage
// - level format: narrow high pulse after the stale set is read out
module adc_result_double_buffer import adb_pkg::*; #(
  parameter int NCH = DEF_NCH,
  parameter int RES_W = DEF_RES_W
) (
  input wire logic clk,                      // system clock, 125 MHz
  input wire logic rst_n,                    // async reset, active low
  input wire logic [NCH-1:0] res_valid,      // per channel new result pulse, clk domain
  input wire logic [NCH*RES_W-1:0] res_data, // results, channel 0 in the low bits
  input wire logic ready_signal_format,      // 0 level, 1 pulse, clk domain
  input wire logic sclk,                     // serial clock pin from the host
  input wire logic cs_n,                     // frame select pin, active low
  input wire logic sync_reset_n,             // resync pin, active low strobe
  output logic dout,                         // serial data, changes on sclk fall
  output logic sample_ready_n,               // ready pin, active low
  output logic [NCH-1:0] ready_flags,        // per channel data ready status bits
  output logic conv_restart                  // pulse to the filters to realign
);
  localparam int FRAME_W = STATUS_W + NCH * RES_W;
  localparam int CNT_W = $clog2(FRAME_W + 1);

  // refuse sizes that the status word or the pin timers cannot carry
  if (NCH < 1 || NCH > STATUS_W || RES_W < 1) begin : g_bad_size
    $error("unsupported channel count or result width");
  end
  if (PULSE_LOW_CYC < 1 || PULSE_LOW_CYC >= 2 ** TMR_W || BRIEF_HIGH_CYC >= 2 ** TMR_W) begin : g_bad_timer
    $error("ready pin widths do not fit the timer");
  end

  // pins cross into clk with two flops; the third stage only remembers the last synced value
  logic [1:0] sclk_s_ff, cs_s_ff, sync_s_ff;
  logic sclk_d_ff, cs_d_ff, sync_d_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s_ff <= 2'h0;
      cs_s_ff <= 2'h3;
      sync_s_ff <= 2'h3;
      sclk_d_ff <= 1'h0;
      cs_d_ff <= 1'h1;
      sync_d_ff <= 1'h1;
    end else begin
      sclk_s_ff <= {sclk_s_ff[0], sclk};
      cs_s_ff <= {cs_s_ff[0], cs_n};
      sync_s_ff <= {sync_s_ff[0], sync_reset_n};
      sclk_d_ff <= sclk_s_ff[1];
      cs_d_ff <= cs_s_ff[1];
      sync_d_ff <= sync_s_ff[1];
    end
  end

  logic sclk_rise, sclk_fall, frame_start, in_frame, flush;
  assign sclk_rise = sclk_s_ff[1] && !sclk_d_ff;
  assign sclk_fall = !sclk_s_ff[1] && sclk_d_ff;
  assign frame_start = !cs_s_ff[1] && cs_d_ff;
  assign in_frame = !cs_s_ff[1];
  assign flush = !sync_s_ff[1] && sync_d_ff;  // falling edge of the resync pin

  // per channel stages
  logic [NCH*RES_W-1:0] queue_all;
  logic [NCH-1:0] unread, pending, qload, read_done;
  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_ch
      adb_chan_stage #(.RES_W(RES_W)) u_stage (
        .clk(clk),
        .rst_n(rst_n),
        .flush(flush),
        .new_valid(res_valid[gc]),
        .new_data(res_data[gc*RES_W +: RES_W]),
        .read_done(read_done[gc]),
        .conv_q(),
        .queue_q(queue_all[gc*RES_W +: RES_W]),
        .unread(unread[gc]),
        .pending(pending[gc]),
        .queue_load(qload[gc])
      );
    end
  endgenerate

  // frame image: status word, then channel 0 first, msb first
  logic [FRAME_W-1:0] frame_img;
  always_comb begin
    frame_img = '0;
    frame_img[FRAME_W-STATUS_W +: NCH] = unread;
    for (int c = 0; c < NCH; c++) begin
      frame_img[FRAME_W-STATUS_W-(c+1)*RES_W +: RES_W] = queue_all[c*RES_W +: RES_W];
    end
  end

  // shifter: snapshot at frame start so a result landing mid-frame cannot tear a word
  // bits past the frame end shift in zeros and the counter stops at the frame length
  logic [FRAME_W-1:0] sh_ff;
  logic [CNT_W-1:0] bit_cnt_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_ff <= '0;
      bit_cnt_ff <= '0;
    end else if (frame_start) begin
      sh_ff <= frame_img;
      bit_cnt_ff <= '0;
    end else if (in_frame) begin
      if (sclk_fall) begin
        sh_ff <= {sh_ff[FRAME_W-2:0], 1'h0};
      end
      if (sclk_rise && bit_cnt_ff != CNT_W'(FRAME_W)) begin
        bit_cnt_ff <= bit_cnt_ff + 1'h1;
      end
    end
  end

  // a word is read on the host edge that takes its last bit; a cut frame never gets there
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      read_done[c] = in_frame && sclk_rise &&
        (bit_cnt_ff == CNT_W'(STATUS_W + (c + 1) * RES_W - 1));
    end
  end

  // ready pin timers
  logic rdy_n_ff, load_evt;
  logic [TMR_W-1:0] tmr_ff;
  // limitation: a channel converting out of step with channel 0 gives no pulse or brief high; it moves the level pin only through its unread flag
  assign load_evt = qload[0];           // channels convert together, so channel 0 paces the pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_ff <= '0;
    end else if (load_evt && ready_signal_format == FMT_PULSE) begin
      tmr_ff <= TMR_W'(PULSE_LOW_CYC);  // skipped loads give no pulse
    end else if (load_evt && !rdy_n_ff) begin
      tmr_ff <= TMR_W'(BRIEF_HIGH_CYC); // pin already low: short high first
    end else if (tmr_ff != '0) begin
      tmr_ff <= tmr_ff - 1'h1;
    end
  end

  // pin level: pulse format is the low timer, level format tracks unread data
  // the brief high costs two cycles of low, but gives the host a fresh falling edge
  logic nxt_rdy_n;
  always_comb begin
    if (ready_signal_format == FMT_PULSE) begin
      nxt_rdy_n = (tmr_ff == '0);
    end else begin
      nxt_rdy_n = (tmr_ff != '0) || !(|unread);
    end
  end

  // outputs, all registered
  logic [NCH-1:0] ready_flags_ff;
  logic conv_restart_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_n_ff <= 1'h1;
      ready_flags_ff <= '0;
      conv_restart_ff <= 1'h0;
    end else begin
      rdy_n_ff <= nxt_rdy_n;
      ready_flags_ff <= unread;
      conv_restart_ff <= flush;
    end
  end
  assign sample_ready_n = rdy_n_ff;
  assign ready_flags = ready_flags_ff;
  assign conv_restart = conv_restart_ff;
  assign dout = sh_ff[FRAME_W-1];

  // checks on the serial side, the read bookkeeping and the pin; the format is held over each window
  a_frame_load: assert property (@(posedge clk) disable iff (!rst_n)
    frame_start |=> sh_ff == $past(frame_img)) else $error("frame not loaded from queue stages");
  a_read_whole: assert property (@(posedge clk) disable iff (!rst_n)
    read_done[0] |-> bit_cnt_ff == CNT_W'(STATUS_W + RES_W - 1)) else $error("read marked before word end");
  a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    read_done[0] && !res_valid[0] && !pending[0] && !flush |=> ##1 !ready_flags[0])
    else $error("ready flag not cleared by read");
  a_pulse_low: assert property (@(posedge clk) disable iff (!rst_n)
    load_evt && ready_signal_format == FMT_PULSE ##1 ready_signal_format == FMT_PULSE |=> !sample_ready_n)
    else $error("no low pulse for new result");
  a_level_high: assert property (@(posedge clk) disable iff (!rst_n)
    ready_signal_format == FMT_LEVEL && tmr_ff == '0 && !(|unread) |=> sample_ready_n)
    else $error("ready low with all data read");
  a_restart: assert property (@(posedge clk) disable iff (!rst_n)
    flush |=> conv_restart ##1 !conv_restart) else $error("restart pulse wrong");

  // pin shape: low while data wait, a brief high on a reload, no pulse without a load
  a_level_low: assert property (@(posedge clk) disable iff (!rst_n)
    ready_signal_format == FMT_LEVEL && tmr_ff == '0 && (|unread) |=> !sample_ready_n)
    else $error("ready high with unread data");
  a_brief_high: assert property (@(posedge clk) disable iff (!rst_n)
    load_evt && !rdy_n_ff && ready_signal_format == FMT_LEVEL ##1 ready_signal_format == FMT_LEVEL
    |=> sample_ready_n) else $error("no brief high before a new fall");
  a_pulse_idle: assert property (@(posedge clk) disable iff (!rst_n)
    ready_signal_format == FMT_PULSE && tmr_ff == '0 && !load_evt ##1 ready_signal_format == FMT_PULSE
    |=> sample_ready_n) else $error("pulse without a queue load");

  // the shifter only moves on a frame start or a synced clock fall; resync clears the flags
  a_shift_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !frame_start && !(in_frame && sclk_fall) |=> $stable(sh_ff))
    else $error("shifter moved without a clock fall");
  a_flush_flags: assert property (@(posedge clk) disable iff (!rst_n)
    flush |=> ##1 ready_flags == '0) else $error("ready flags survive resync");
endmodule : adc_result_double_buffer

// ### bench/adb_host_model.sv
// host side model: frames the serial link and strobes the resync pin
module adb_host_model (
  input wire logic clk,       // system clock, paces the host
  input wire logic dout,      // serial data from the block
  output logic sclk,          // serial clock, still outside frames
  output logic cs_n,          // frame select, active low
  output logic sync_reset_n   // resync pin, active low strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle levels the pin synchronisers expect during reset
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    sync_reset_n = 1'h1;
  end
  // frame of nbits, 160 ns sclk; bit taken at each rise, status word first
  task automatic read_frame(input int nbits, output logic [63:0] w);
    w = 64'h0;
    @(posedge clk) cs_n <= 1'h0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk) sclk <= 1'h1;
      w = {w[62:0], dout}; // dout moves only after a fall, so it is settled here
      repeat (9) @(posedge clk);
      @(posedge clk) sclk <= 1'h0;
      repeat (9) @(posedge clk);
    end
    @(posedge clk) cs_n <= 1'h1;
    repeat (6) @(posedge clk);
  endtask
  // resync strobe held long enough for the synchronisers, then a pause
  task automatic strobe_sync();
    @(posedge clk) sync_reset_n <= 1'h0;
    repeat (6) @(posedge clk);
    @(posedge clk) sync_reset_n <= 1'h1;
    repeat (6) @(posedge clk);
  endtask
endmodule // adb_host_model

// ### bench/adc_result_double_buffer_bench.sv
// self-checking bench for the conversion result double buffer
module adc_result_double_buffer_bench import adb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, fmt, sclk, cs_n, sync_reset_n, dout, sample_ready_n, conv_restart;
  logic [DEF_NCH-1:0] res_valid, ready_flags;
  logic [DEF_NCH*DEF_RES_W-1:0] res_data;
  logic [63:0] w;
  int error_cnt = 0;
  int cmp_count = 0;
  int restarts = 0;
  int n;
  int rises = 0;
  adc_result_double_buffer u_adc_result_double_buffer (.clk(clk), .rst_n(rst_n), .res_valid(res_valid),
    .res_data(res_data), .ready_signal_format(fmt), .sclk(sclk), .cs_n(cs_n), .sync_reset_n(sync_reset_n),
    .dout(dout), .sample_ready_n(sample_ready_n), .ready_flags(ready_flags), .conv_restart(conv_restart));
  adb_host_model u_adb_host_model (.clk(clk), .dout(dout), .sclk(sclk), .cs_n(cs_n),
    .sync_reset_n(sync_reset_n));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // restart pulses are counted, so a stuck or doubled pulse shows
  always @(posedge clk) if (conv_restart === 1'h1) restarts++;
  // ready pin rises are counted, so a narrow high that the clocked checks miss still shows
  always @(posedge sample_ready_n) rises++;
  function automatic logic [63:0] fr(input logic [1:0] f, input logic [47:0] d);
    return {14'h0, f, d[23:0], d[47:24]};
  endfunction
  task automatic chk_vec(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (e !== g) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_vec(nm, {63'h0, e}, {63'h0, g});
  endtask
  task automatic push(input logic [47:0] d);
    @(posedge clk) res_valid <= 2'h3;
    res_data <= d;
    @(posedge clk) res_valid <= 2'h0;
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rd(input logic [63:0] e);
    u_adb_host_model.read_frame(64, w);
    chk_vec("frame", e, w);
    settle();
  endtask
  task automatic count_low(output int c);
    c = 0;
    repeat (20) @(posedge clk) if (sample_ready_n === 1'h0) c++;
  endtask
  task automatic t_reset();
    @(negedge clk);
    chk_bit("ready pin", 1'h1, sample_ready_n);
    chk_vec("flags", 64'h0, 64'(ready_flags));
    chk_bit("restart", 1'h0, conv_restart);
  endtask
  task automatic t_read_each();
    push(48'hA1A2A3_B1B2B3);
    settle();
    chk_vec("flags", 64'h3, 64'(ready_flags));
    chk_bit("ready pin", 1'h0, sample_ready_n);
    rd(fr(2'h3, 48'hA1A2A3_B1B2B3));
    chk_vec("flags", 64'h0, 64'(ready_flags));
    chk_bit("ready pin", 1'h1, sample_ready_n);
    rd(fr(2'h0, 48'hA1A2A3_B1B2B3));
  endtask
  task automatic t_miss_one();
    push(48'h111111_222222);
    push(48'h333333_444444);
    settle();
    n = rises;
    rd(fr(2'h3, 48'h111111_222222));
    chk_vec("narrow pulse", 64'h1, 64'(rises - n));
    chk_vec("flags", 64'h3, 64'(ready_flags));
    chk_bit("ready pin", 1'h0, sample_ready_n);
    rd(fr(2'h3, 48'h333333_444444));
    chk_vec("flags", 64'h0, 64'(ready_flags));
  endtask
  task automatic t_miss_two();
    n = rises;
    push(48'h555555_666666);
    push(48'h777777_888888);
    push(48'h99AA99_BBCCBB);
    settle();
    chk_vec("brief high", 64'h1, 64'(rises - n));
    u_adb_host_model.read_frame(30, w);
    chk_vec("cut frame", fr(2'h3, 48'h99AA99_BBCCBB) >> 34, w);
    settle();
    chk_vec("flags", 64'h3, 64'(ready_flags));
    rd(fr(2'h3, 48'h99AA99_BBCCBB));
    chk_vec("flags", 64'h0, 64'(ready_flags));
  endtask
  task automatic t_resync();
    push(48'hC0FFEE_0DDBA1);
    settle();
    u_adb_host_model.strobe_sync();
    settle();
    chk_vec("restarts", 64'h1, 64'(restarts));
    chk_vec("flags", 64'h0, 64'(ready_flags));
    chk_bit("ready pin", 1'h1, sample_ready_n);
    rd(fr(2'h0, 48'h0));
  endtask
  // reset in mid-run: stages empty, pin and flags back to idle, first frame all zero
  task automatic t_midreset();
    push(48'h13579B_2468AC);
    settle();
    chk_vec("flags", 64'h3, 64'(ready_flags));
    @(posedge clk) rst_n <= 1'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
    t_reset();
    rd(fr(2'h0, 48'h0));
  endtask
  task automatic t_pulse();
    @(posedge clk) fmt <= 1'h1;
    settle();
    push(48'h123456_789ABC);
    count_low(n);
    chk_vec("pulse", 64'(PULSE_LOW_CYC), 64'(n));
    push(48'hFEDCBA_987654);
    count_low(n);
    chk_vec("pulse", 64'h0, 64'(n));
    push(48'h0F0F0F_F0F0F0);
    count_low(n);
    chk_vec("pulse", 64'(PULSE_LOW_CYC), 64'(n));
    rd(fr(2'h3, 48'h0F0F0F_F0F0F0));
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: the tests need about 90 us
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'h0;
    res_valid = 2'h0;
    res_data = 48'h0;
    fmt = 1'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
    t_reset();
    t_read_each();
    t_miss_one();
    t_miss_two();
    t_resync();
    t_midreset();
    t_pulse();
    report_and_stop();
  end
endmodule // adc_result_double_buffer_bench
